/* hw/tdp_dialer.sv */
// Tone and pulse telephone dialer core
`timescale 1ns/1ps

module tdp_dialer #(
    parameter int MS_CYCLES = tdp_pkg::CLK_HZ / 1000
) (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  resetn,
    // Register port
    input  wire tdp_pkg::tdp_bus_req_t bus_req,
    output logic [15:0]                bus_rdata,
    // Keypad and switches
    input  wire tdp_pkg::tdp_key_t     key_in,
    input  wire logic                  dial_type_switch,
    input  wire logic                  cancel_switch,
    // Line side
    output logic                       hook_relay,
    output logic                       hook_indicator,
    output logic [3:0]                 dac_out
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    localparam tdp_pkg::tdp_rom_t TONE_ROM = tdp_pkg::tdp_build_rom();

    tdp_pkg::tdp_state_t state_q;
    tdp_pkg::tdp_state_t state_d;
    logic [15:0]         burst_q;
    logic [15:0]         burst_left_q;
    logic [15:0]         div_q;
    logic [7:0]          ms_q;
    logic [3:0]          pulses_q;
    logic [11:0]         samp_q;
    logic [11:0]         gap_q;
    logic [6:0]          ptr_lo_q;
    logic [6:0]          ptr_hi_q;
    logic [6:0]          start_lo_q;
    logic [6:0]          start_hi_q;
    logic [3:0]          digit_q;
    logic [3:0]          dac_q;
    logic                relay_q;
    logic                hook_q;
    logic [15:0]         rdata_q;
    logic [15:0]         status;
    logic                sw_dial;
    logic                key_go;
    logic [3:0]          key_code;
    logic [3:0]          pair;
    logic                pulse_state;
    logic                ms_tick;
    logic                brk_done;
    logic                mk_done;
    logic                gap_done;
    logic                samp_tick;
    logic                tone_start;
    logic [3:0]          lo_raw;
    logic [3:0]          hi_raw;
    logic [3:0]          lo_smp;
    logic [3:0]          hi_smp;
    logic [3:0]          dac_sum;

    // ------------------------------------------------------------------
    // Digit sources and decode
    // ------------------------------------------------------------------
    // Keypad wins over a software dial in the same cycle
    assign sw_dial  = bus_req.wr && bus_req.addr == tdp_pkg::REG_DIAL;
    assign key_go   = key_in.valid || sw_dial;
    assign key_code = key_in.valid ? key_in.code : bus_req.wdata[3:0];
    assign pair     = tdp_pkg::tdp_pair(key_code);

    assign pulse_state = state_q == tdp_pkg::ST_BREAK || state_q == tdp_pkg::ST_MAKE ||
                         state_q == tdp_pkg::ST_GAP;
    assign ms_tick   = div_q == 16'(MS_CYCLES - 1);
    assign brk_done  = ms_tick && ms_q == 8'(tdp_pkg::BREAK_MS - 1);
    assign mk_done   = ms_tick && ms_q == 8'(tdp_pkg::MAKE_MS - 1);
    assign gap_done  = ms_tick && ms_q == 8'(tdp_pkg::GAP_MS - 1);
    assign samp_tick = samp_q == 12'(tdp_pkg::SAMPLE_CYCLES - 1);
    assign tone_start = state_q == tdp_pkg::ST_IDLE && state_d == tdp_pkg::ST_TONE;

    // ------------------------------------------------------------------
    // Control sequence
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            tdp_pkg::ST_ON_HOOK: begin
                if (key_go) state_d = tdp_pkg::ST_IDLE;
            end
            tdp_pkg::ST_IDLE: begin
                if (key_go) begin
                    if (dial_type_switch) state_d = tdp_pkg::ST_TONE;
                    else if (key_code <= 4'h9) state_d = tdp_pkg::ST_BREAK;
                end
            end
            tdp_pkg::ST_BREAK: begin
                if (brk_done) state_d = tdp_pkg::ST_MAKE;
            end
            tdp_pkg::ST_MAKE: begin
                if (mk_done) begin
                    state_d = (pulses_q == 4'h1) ? tdp_pkg::ST_GAP : tdp_pkg::ST_BREAK;
                end
            end
            tdp_pkg::ST_GAP: begin
                if (gap_done) state_d = tdp_pkg::ST_IDLE;
            end
            tdp_pkg::ST_TONE: begin
                if (samp_tick && burst_left_q == 16'h1) state_d = tdp_pkg::ST_IDLE;
            end
            default: state_d = tdp_pkg::ST_ON_HOOK;
        endcase
        if (cancel_switch) state_d = tdp_pkg::ST_ON_HOOK;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) state_q <= tdp_pkg::ST_ON_HOOK;
        else state_q <= state_d;
    end

    // Line outputs follow the next state so they align with state_q
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            relay_q <= 1'b0;
            hook_q  <= 1'b0;
        end else begin
            relay_q <= state_d != tdp_pkg::ST_ON_HOOK && state_d != tdp_pkg::ST_BREAK;
            hook_q  <= state_d != tdp_pkg::ST_ON_HOOK;
        end
    end

    // ------------------------------------------------------------------
    // Pulse timing
    // ------------------------------------------------------------------
    // Millisecond divider restarts on every phase change
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            div_q <= '0;
            ms_q  <= '0;
        end else if (!pulse_state || state_d != state_q) begin
            div_q <= '0;
            ms_q  <= '0;
        end else if (ms_tick) begin
            div_q <= '0;
            ms_q  <= ms_q + 8'h1;
        end else begin
            div_q <= div_q + 16'h1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pulses_q <= '0;
        end else if (state_q == tdp_pkg::ST_IDLE && state_d == tdp_pkg::ST_BREAK) begin
            pulses_q <= (key_code == 4'h0) ? 4'(tdp_pkg::DIGIT_TEN) : key_code;
        end else if (state_q == tdp_pkg::ST_MAKE && mk_done) begin
            pulses_q <= pulses_q - 4'h1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) digit_q <= '0;
        else if (state_q == tdp_pkg::ST_IDLE && state_d != tdp_pkg::ST_IDLE) digit_q <= key_code;
    end

    // ------------------------------------------------------------------
    // Tone generation
    // ------------------------------------------------------------------
    // Own sample divider, untouched by pulse timing, restarted at each tone start and strobe
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) samp_q <= '0;
        else if (tone_start || samp_tick) samp_q <= '0;
        else samp_q <= samp_q + 12'h1;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            start_lo_q <= '0;
            start_hi_q <= '0;
        end else if (tone_start) begin
            start_lo_q <= tdp_pkg::tdp_start(1'b0, pair[3:2]);
            start_hi_q <= tdp_pkg::tdp_start(1'b1, pair[1:0]);
        end
    end

    assign lo_raw  = TONE_ROM[ptr_lo_q][7:4];
    assign hi_raw  = TONE_ROM[ptr_hi_q][3:0];
    assign lo_smp  = (lo_raw == tdp_pkg::END_MARK) ? TONE_ROM[start_lo_q][7:4] : lo_raw;
    assign hi_smp  = (hi_raw == tdp_pkg::END_MARK) ? TONE_ROM[start_hi_q][3:0] : hi_raw;
    assign dac_sum = {1'b0, lo_smp[2:0]} + {1'b0, hi_smp[2:0]};

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ptr_lo_q <= '0;
            ptr_hi_q <= '0;
        end else if (tone_start) begin
            ptr_lo_q <= tdp_pkg::tdp_start(1'b0, pair[3:2]);
            ptr_hi_q <= tdp_pkg::tdp_start(1'b1, pair[1:0]);
        end else if (state_q == tdp_pkg::ST_TONE && samp_tick) begin
            ptr_lo_q <= (lo_raw == tdp_pkg::END_MARK) ? start_lo_q + 7'h1 : ptr_lo_q + 7'h1;
            ptr_hi_q <= (hi_raw == tdp_pkg::END_MARK) ? start_hi_q + 7'h1 : ptr_hi_q + 7'h1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) burst_left_q <= '0;
        else if (tone_start) burst_left_q <= burst_q;
        else if (state_q == tdp_pkg::ST_TONE && samp_tick) burst_left_q <= burst_left_q - 16'h1;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) dac_q <= '0;
        else if (state_q != tdp_pkg::ST_TONE) dac_q <= '0;
        else if (samp_tick) dac_q <= dac_sum;
    end

    // ------------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) burst_q <= tdp_pkg::BURST_RST;
        else if (bus_req.wr && bus_req.addr == tdp_pkg::REG_BURST) burst_q <= bus_req.wdata;
    end

    always_comb begin
        status = '0;
        status[tdp_pkg::ST_HOOK_BIT] = hook_q;
        status[tdp_pkg::ST_BUSY_BIT] = state_q != tdp_pkg::ST_IDLE &&
                                       state_q != tdp_pkg::ST_ON_HOOK;
        status[tdp_pkg::ST_TONE_BIT] = state_q == tdp_pkg::ST_TONE;
        status[tdp_pkg::ST_DIGIT_LSB +: 4] = digit_q;
    end

    // Read data stand for one cycle only, unmapped reads give zero
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= '0;
        end else if (bus_req.rd) begin
            case (bus_req.addr)
                tdp_pkg::REG_BURST:  rdata_q <= burst_q;
                tdp_pkg::REG_STATUS: rdata_q <= status;
                default:             rdata_q <= '0;
            endcase
        end else begin
            rdata_q <= '0;
        end
    end

    assign bus_rdata      = rdata_q;
    assign hook_relay     = relay_q;
    assign hook_indicator = hook_q;
    assign dac_out        = dac_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    // Cycles since the last sample strobe, checked against the period
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) gap_q <= '0;
        else if (tone_start || samp_tick) gap_q <= '0;
        else if (gap_q != 12'hfff) gap_q <= gap_q + 12'h1;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_first_key_offhook: assert property (
        (state_q == tdp_pkg::ST_ON_HOOK && key_go && !cancel_switch) |=>
        (state_q == tdp_pkg::ST_IDLE && hook_relay && dac_out == 4'h0))
        else $error("first key did not just go off-hook");

    a_cancel_hook: assert property (
        cancel_switch |=> (state_q == tdp_pkg::ST_ON_HOOK && !hook_relay && !hook_indicator))
        else $error("cancel did not return on-hook");

    a_hook_indicator: assert property (
        hook_indicator == (state_q != tdp_pkg::ST_ON_HOOK))
        else $error("hook indicator disagrees with hook state");

    a_break_time: assert property (
        (state_q == tdp_pkg::ST_BREAK && brk_done && !cancel_switch) |->
        (ms_q == 8'd60 && !hook_relay) ##1 (state_q == tdp_pkg::ST_MAKE && hook_relay))
        else $error("break phase length wrong");

    a_pulse_train_end: assert property (
        (state_q == tdp_pkg::ST_MAKE && mk_done && pulses_q == 4'h1 && !cancel_switch) |->
        ms_q == 8'd38 ##1 state_q == tdp_pkg::ST_GAP)
        else $error("pulse train did not end in pause");

    a_pulse_load: assert property (
        (state_q == tdp_pkg::ST_IDLE && state_d == tdp_pkg::ST_BREAK) |=>
        pulses_q == (($past(key_code) == 4'h0) ? 4'ha : $past(key_code)))
        else $error("pulse count not loaded from digit");

    a_letter_ignored: assert property (
        (state_q == tdp_pkg::ST_IDLE && key_go && !dial_type_switch &&
         key_code > 4'h9 && !cancel_switch) |=> state_q == tdp_pkg::ST_IDLE)
        else $error("letter key dialed in pulse mode");

    a_gap_hold: assert property (
        (state_q == tdp_pkg::ST_GAP && gap_done && !cancel_switch) |->
        (ms_q == 8'd199 && hook_relay) ##1 state_q == tdp_pkg::ST_IDLE)
        else $error("inter-digit pause wrong");

    a_tone_select: assert property (
        (state_q == tdp_pkg::ST_IDLE && key_go && dial_type_switch && !cancel_switch) |=>
        (state_q == tdp_pkg::ST_TONE && ptr_lo_q == start_lo_q && ptr_hi_q == start_hi_q))
        else $error("tone digit did not start tone tables");

    a_dac_sum: assert property (
        (state_q == tdp_pkg::ST_TONE && samp_tick && !cancel_switch &&
         burst_left_q != 16'h1) |=> dac_out == $past(dac_sum))
        else $error("DAC word is not the sample sum");

    a_wrap_reload: assert property (
        (state_q == tdp_pkg::ST_TONE && samp_tick && lo_raw == tdp_pkg::END_MARK) |=>
        ptr_lo_q == start_lo_q + 7'h1)
        else $error("low table did not wrap to start");

    a_hi_wrap_reload: assert property (
        (state_q == tdp_pkg::ST_TONE && samp_tick && hi_raw == tdp_pkg::END_MARK) |=>
        ptr_hi_q == start_hi_q + 7'h1)
        else $error("high table did not wrap to start");

    a_sample_period: assert property (
        (state_q == tdp_pkg::ST_TONE && samp_tick) |-> gap_q == 12'd3049)
        else $error("sample period not constant");

    a_burst_end: assert property (
        (state_q == tdp_pkg::ST_TONE && samp_tick && burst_left_q == 16'h1 &&
         !cancel_switch) |=> (state_q == tdp_pkg::ST_IDLE ##1 dac_out == 4'h0))
        else $error("tone burst did not stop");

    c_pulse_digit: cover property (state_q == tdp_pkg::ST_GAP && gap_done);
    c_tone_burst: cover property (state_q == tdp_pkg::ST_TONE && state_d == tdp_pkg::ST_IDLE);
    c_table_wrap: cover property (state_q == tdp_pkg::ST_TONE && samp_tick &&
                                  hi_raw == tdp_pkg::END_MARK);
    c_cancel_tone: cover property (state_q == tdp_pkg::ST_TONE && cancel_switch);

endmodule

/* common/tdp_pkg.sv */
// Constants, types and tone-table builder for the tone/pulse dialer
package tdp_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ        = 25_000_000;
    localparam int SAMPLE_US     = 122;
    localparam int SAMPLE_CYCLES = CLK_HZ / 1_000_000 * SAMPLE_US;
    localparam int BREAK_MS      = 61;
    localparam int MAKE_MS       = 39;
    localparam int GAP_MS        = 200;
    localparam int DIGIT_TEN     = 10;

    // ------------------------------------------------------------------
    // Registers and fields
    // ------------------------------------------------------------------
    localparam logic [3:0]  REG_BURST    = 4'h0;
    localparam logic [3:0]  REG_DIAL     = 4'h1;
    localparam logic [3:0]  REG_STATUS   = 4'h2;
    localparam logic [15:0] BURST_RST    = 16'h0334;
    localparam logic [3:0]  END_MARK     = 4'hf;
    localparam int          ST_HOOK_BIT  = 0;
    localparam int          ST_BUSY_BIT  = 1;
    localparam int          ST_TONE_BIT  = 2;
    localparam int          ST_DIGIT_LSB = 4;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  addr;
        logic [15:0] wdata;
    } tdp_bus_req_t;

    typedef struct packed {
        logic       valid;
        logic [3:0] code;
    } tdp_key_t;

    typedef enum logic [5:0] {
        ST_ON_HOOK = 6'h01,
        ST_IDLE    = 6'h02,
        ST_BREAK   = 6'h04,
        ST_MAKE    = 6'h08,
        ST_GAP     = 6'h10,
        ST_TONE    = 6'h20
    } tdp_state_t;

    typedef logic [127:0][7:0] tdp_rom_t;

    // ------------------------------------------------------------------
    // Tone tables
    // ------------------------------------------------------------------
    // Low group 697/770/852/941, high group 1209/1336/1477/1633
    localparam int LO_LEN [4] = '{35, 32, 29, 26};
    localparam int LO_CYC [4] = '{3, 3, 3, 3};
    localparam int HI_LEN [4] = '{27, 37, 11, 5};
    localparam int HI_CYC [4] = '{4, 6, 2, 1};
    // One sine period in 16 phases, positive peak first
    localparam logic [15:0][2:0] COS16 = {3'h7, 3'h6, 3'h5, 3'h4, 3'h2, 3'h1,
        3'h0, 3'h0, 3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7, 3'h7};

    function automatic int tdp_len(input logic grp, input logic [1:0] t);
        return grp ? HI_LEN[t] : LO_LEN[t];
    endfunction

    function automatic int tdp_cyc(input logic grp, input logic [1:0] t);
        return grp ? HI_CYC[t] : LO_CYC[t];
    endfunction

    // Table start address of tone idx in a group
    function automatic logic [6:0] tdp_start(input logic grp, input logic [1:0] idx);
        logic [6:0] a;
        a = '0;
        for (int t = 0; t < 4; t++) begin
            if (2'(t) < idx) a = a + 7'(tdp_len(grp, 2'(t)) + 1);
        end
        return a;
    endfunction

    // Low-group samples in the upper nibble, high group in the lower
    function automatic tdp_rom_t tdp_build_rom();
        tdp_rom_t   r;
        int         a;
        int         ln;
        int         ph;
        logic [3:0] nib;
        r = '0;
        for (int g = 0; g < 2; g++) begin
            a = 0;
            for (int t = 0; t < 4; t++) begin
                ln = tdp_len(1'(g), 2'(t));
                for (int n = 0; n <= ln; n++) begin
                    ph = ((tdp_cyc(1'(g), 2'(t)) * n * 16 + ln / 2) / ln) % 16;
                    nib = (n == ln) ? END_MARK : {1'b0, COS16[ph]};
                    if (g == 0) r[a][7:4] = nib;
                    else r[a][3:0] = nib;
                    a++;
                end
            end
        end
        return r;
    endfunction

    // Digit code to {low index, high index}
    function automatic logic [3:0] tdp_pair(input logic [3:0] code);
        logic [1:0] lo;
        logic [1:0] hi;
        lo = 2'h3;
        hi = 2'h1;
        if (code >= 4'h1 && code <= 4'h9) begin
            lo = 2'((code - 4'h1) / 4'h3);
            hi = 2'((code - 4'h1) % 4'h3);
        end else if (code >= 4'ha && code <= 4'hd) begin
            lo = code[1:0] - 2'h2;
            hi = 2'h3;
        end else if (code == 4'he) begin
            hi = 2'h0;
        end else if (code == 4'hf) begin
            hi = 2'h2;
        end
        return {lo, hi};
    endfunction

endpackage

/* tb/tdp_line_model.sv */
// Telephone line model that counts loop breaks made through the hook relay
`timescale 1ns/1ps

module tdp_line_model (
    // Clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // Line side of the dialer
    input  wire logic hook_relay,
    input  wire logic hook_indicator,
    // Observations
    output int        pulses,
    output int        break_len
);
    int run;

    // A break only counts while the dialer claims to be off-hook
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pulses    <= 0;
            break_len <= 0;
            run       <= 0;
        end else if (!hook_indicator) begin
            run <= 0;
        end else if (!hook_relay) begin
            run <= run + 1;
        end else if (run > 0) begin
            pulses    <= pulses + 1;
            break_len <= run;
            run       <= 0;
        end
    end
endmodule

/* tb/testbench.sv */
// Self-checking bench for the tone and pulse dialer
`timescale 1ns/1ps

module testbench;
    localparam int MS = 10;
    logic                  clk = 1'b0;
    logic                  resetn = 1'b0;
    tdp_pkg::tdp_bus_req_t bus_req = '0;
    tdp_pkg::tdp_key_t     key_in = '0;
    logic                  dial_type_switch = 1'b0;
    logic                  cancel_switch = 1'b0;
    logic [15:0]           bus_rdata;
    logic                  hook_relay;
    logic                  hook_indicator;
    logic [3:0]            dac_out;
    logic [15:0]           rv;
    int                    pulses;
    int                    break_len;
    int                    n_mismatch = 0;
    int                    n_tests = 0;

    always #20 clk = ~clk;

    tdp_dialer #(.MS_CYCLES(MS)) uut (.clk(clk), .resetn(resetn), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .key_in(key_in), .dial_type_switch(dial_type_switch),
        .cancel_switch(cancel_switch), .hook_relay(hook_relay),
        .hook_indicator(hook_indicator), .dac_out(dac_out));

    tdp_line_model line (.clk(clk), .resetn(resetn), .hook_relay(hook_relay),
        .hook_indicator(hook_indicator), .pulses(pulses), .break_len(break_len));

    task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        bus_req <= '0;
        #1;
    endtask

    task automatic bus_rd(input logic [3:0] a);
        @(posedge clk);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge clk);
        bus_req <= '0;
        #1 rv = bus_rdata;
    endtask

    task automatic press(input logic [3:0] c);
        @(posedge clk);
        key_in <= '{valid: 1'b1, code: c};
        @(posedge clk);
        key_in <= '0;
        #1;
    endtask

    task automatic wait_idle();
        for (int i = 0; i < 20000; i++) begin
            bus_rd(tdp_pkg::REG_STATUS);
            if (rv[tdp_pkg::ST_BUSY_BIT] === 1'b0) break;
        end
        chk("idle", 16'h0, 16'(rv[tdp_pkg::ST_BUSY_BIT]));
    endtask

    task automatic t_reset();
        chk("relay", 16'h0, 16'(hook_relay));
        chk("indicator", 16'h0, 16'(hook_indicator));
        bus_rd(4'h7);
        chk("unmapped", 16'h0, rv);
        press(4'h5);
        chk("indicator", 16'h1, 16'(hook_indicator));
        repeat (50) @(posedge clk);
        chk("pulses", 16'h0, 16'(pulses));
    endtask

    task automatic t_pulse(input logic [3:0] c, input int n, input logic via_reg);
        int  p0;
        time t0;
        p0 = pulses;
        if (via_reg) bus_wr(tdp_pkg::REG_DIAL, {12'h000, c});
        else press(c);
        t0 = $time;
        chk("break", 16'h0, 16'(hook_relay));
        wait_idle();
        chk("count", 16'(n), 16'(pulses - p0));
        chk("break len", 16'(61 * MS), 16'(break_len));
        chk("span", 16'h1, 16'(($time - t0) / 40 - n * 100 * MS - 200 * MS < 8));
        chk("indicator", 16'h1, 16'(hook_indicator));
    endtask

    task automatic t_letter();
        int p0;
        p0 = pulses;
        press(4'ha);
        chk("letter relay", 16'h1, 16'(hook_relay));
        repeat (100) @(posedge clk);
        chk("letter", 16'(p0), 16'(pulses));
    endtask

    task automatic t_tone();
        bus_wr(tdp_pkg::REG_BURST, 16'h0002);
        bus_rd(tdp_pkg::REG_BURST);
        chk("burst reg", 16'h0002, rv);
        @(posedge clk);
        dial_type_switch <= 1'b1;
        press(4'h5);
        chk("dac start", 16'h0, 16'(dac_out));
        bus_rd(tdp_pkg::REG_STATUS);
        chk("tone bit", 16'h1, 16'(rv[tdp_pkg::ST_TONE_BIT]));
        chk("digit", 16'h5, 16'(rv[tdp_pkg::ST_DIGIT_LSB +: 4]));
        repeat (3048) @(posedge clk);
        #1 chk("peak", 16'he, 16'(dac_out));
        repeat (3049) @(posedge clk);
        #1 chk("hold", 16'he, 16'(dac_out));
        @(posedge clk);
        #1 chk("next", 16'hb, 16'(dac_out));
        wait_idle();
        chk("dac end", 16'h0, 16'(dac_out));
    endtask

    // Tone switch is still set; the 1633 Hz table wraps at its sixth sample
    task automatic t_wrap();
        bus_wr(tdp_pkg::REG_BURST, 16'h0007);
        press(4'ha);
        repeat (18300) @(posedge clk);
        #1 chk("wrap", 16'h7, 16'(dac_out));
        repeat (3050) @(posedge clk);
        #1 chk("reload", 16'h5, 16'(dac_out));
        wait_idle();
        chk("wrap end", 16'h0, 16'(dac_out));
    endtask

    task automatic t_cancel();
        press(4'h7);
        @(posedge clk);
        cancel_switch <= 1'b1;
        @(posedge clk);
        #1 chk("cancel", 16'h0, 16'(hook_indicator));
        press(4'h1);
        chk("held", 16'h0, 16'(hook_relay));
        @(posedge clk);
        cancel_switch <= 1'b0;
        dial_type_switch <= 1'b0;
    endtask

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        #1 t_reset();
        t_pulse(4'h3, 3, 1'b0);
        t_pulse(4'h0, 10, 1'b1);
        t_letter();
        t_tone();
        t_wrap();
        t_cancel();
        finish_test();
    end

    // Run needs about 45000 cycles
    initial begin
        #3_000_000;
        n_mismatch++;
        finish_test();
    end
endmodule
